// ### hw/gpei_port.sv
// module: eight-pin gpio port with alternate functions and external interrupt request
//
// Contract
// (R1) up to eight pins, each input with or without interrupt, or output
// (R2) bit x of data, direction and option registers maps to pin x
// (R3) direction bit clear makes an input; data read returns the pin level
// (R4) in input mode the option bit picks the input variant
// (R5) data write in input mode only updates the latch, pin unchanged
// (R6) software loads the data latch before turning a pin into output
// (R7) software avoids bit set or clear read-modify-write on the data register
// (R8) an input-with-interrupt pin raises the external request on an event
// (R9) sensitivity bits select the edge or level for external interrupts
// (R10) enabled pins are qualified by sensitivity, then ORed into one request
// (R11) request latch is hidden from software, cleared by the vector fetch
// (R12) a write changing the sensitivity bits clears a pending request
// (R13) direction bit set makes an output driven from the data latch
// (R14) in output mode a data read returns the latch, not the pin
// (R15) option picks push-pull or open drain; 0 drives low, 1 high or released
// (R16) a peripheral claiming a pin overrides the normal port programming
// (R17) a peripheral driving a pin forces output, with its own drive type
// (R18) peripheral inputs use input mode; data reads still return the pin level
// (R19) a pin used by a peripheral both ways is set as floating input
// (R20) input pin driven by its alternate output reads back that output
// (R21) output pin with alternate input feeds the latch level to the peripheral
// (R22) software never enables an alternate function on an interrupt input
// (R23) dir 0: option 0 floating, 1 pull-up; dir 1: option 0 od, 1 push-pull
// (R24) sensitivity: fall and low, rise only, fall only, both edges
// (R25) sensitivity bits take writes only at interrupt mask level three
// (R26) data, direction and option reset to zero: all pins floating inputs
// (R27) pin inputs are synchronised before reads and interrupt detection
module gpei_port
  import gpei_pkg::*;
#(
  parameter logic [GPEI_PINS-1:0] IRQ_CAPABLE = 8'hff,
  parameter logic [GPEI_PINS-1:0] PULL_UP_CAPABLE = 8'hff
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire gpei_bus_req_type bus_req,
  output logic [GPEI_PINS-1:0] bus_rdata,
  input wire logic [1:0] condition_code_reg,
  input wire logic vector_fetch,
  output logic ext_irq_req,
  input wire logic [GPEI_PINS-1:0] pin_in,
  output gpei_pad_type pad,
  input wire gpei_alt_type alt,
  output logic [GPEI_PINS-1:0] alt_in
);

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  logic [GPEI_PINS-1:0] pin_level;
  logic [GPEI_PINS-1:0] pin_level_prev;

  // every pin level is synchronised before any use
  gpei_pin_sync #(
    .WIDTH(GPEI_PINS)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in(pin_in),
    .level(pin_level), // see (R27)
    .level_prev(pin_level_prev)
  );

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [GPEI_PINS-1:0] pin_data_latch_ff;
  logic [GPEI_PINS-1:0] port_pin_direction_ff;
  logic [GPEI_PINS-1:0] port_pin_option_ff;
  logic [1:0] sens_ff;
  logic [GPEI_PINS-1:0] nxt_pin_data_latch;
  logic [GPEI_PINS-1:0] nxt_port_pin_direction;
  logic [GPEI_PINS-1:0] nxt_port_pin_option;
  logic [1:0] nxt_sens;
  logic sens_wr_ok;
  logic sens_changed;

  // a sensitivity write is taken only at mask level three
  assign sens_wr_ok = bus_req.wr && (bus_req.addr == GPEI_OFS_EXT_IRQ_SENSITIVITY_REG)
    && (condition_code_reg == GPEI_CC_LEVEL_UNLOCK); // see (R25)
  assign sens_changed = sens_wr_ok && (bus_req.wdata[1:0] != sens_ff); // see (R12)

  // register writes; the latch takes any data write whatever the direction
  always_comb begin
    nxt_pin_data_latch = pin_data_latch_ff;
    nxt_port_pin_direction = port_pin_direction_ff;
    nxt_port_pin_option = port_pin_option_ff;
    nxt_sens = sens_ff;
    if (bus_req.wr) begin
      case (bus_req.addr)
        GPEI_OFS_PORT_PIN_DATA: begin
          nxt_pin_data_latch = bus_req.wdata; // see (R5) see (R2)
        end
        GPEI_OFS_PORT_PIN_DIRECTION: begin
          nxt_port_pin_direction = bus_req.wdata;
        end
        GPEI_OFS_PORT_PIN_OPTION: begin
          nxt_port_pin_option = bus_req.wdata;
        end
        default: begin
          nxt_sens = sens_ff;
        end
      endcase
    end
    if (sens_wr_ok) begin
      nxt_sens = {bus_req.wdata[GPEI_SENS_FIELD_HIGH_POS],
                  bus_req.wdata[GPEI_SENS_FIELD_LOW_POS]}; // see (R9)
    end
  end

  // registers reset so that every pin starts as a floating input
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_data_latch_ff <= GPEI_RST_PIN_DATA; // see (R26)
      port_pin_direction_ff <= GPEI_RST_PIN_DIRECTION;
      port_pin_option_ff <= GPEI_RST_PIN_OPTION;
      sens_ff <= GPEI_RST_SENSITIVITY;
    end else begin
      pin_data_latch_ff <= nxt_pin_data_latch;
      port_pin_direction_ff <= nxt_port_pin_direction;
      port_pin_option_ff <= nxt_port_pin_option;
      sens_ff <= nxt_sens;
    end
  end

  // ------------------------------------------------------------
  // per-pin views: read value, drive, interrupt qualification
  // ------------------------------------------------------------
  logic [GPEI_PINS-1:0] read_view;
  logic [GPEI_PINS-1:0] drv_out;
  logic [GPEI_PINS-1:0] drv_oe;
  logic [GPEI_PINS-1:0] drv_pull;
  logic [GPEI_PINS-1:0] irq_qual;

  genvar gi;
  generate
    for (gi = 0; gi < GPEI_PINS; gi++) begin : g_pin
      logic is_out;
      logic irq_en;
      logic rise;
      logic fall;

      // direction bit set means output mode
      assign is_out = port_pin_direction_ff[gi]; // see (R3) see (R13)

      // read: latch in output, alternate output or pin level in input
      assign read_view[gi] = is_out ? pin_data_latch_ff[gi] // see (R14)
        : (alt.out_en[gi] ? alt.out_val[gi] // see (R20)
        : pin_level[gi]); // see (R3) see (R18)

      // peripheral input sees the latch in output mode, the pin otherwise
      assign alt_in[gi] = is_out ? pin_data_latch_ff[gi] : pin_level[gi]; // see (R21)

      // drive: a claiming peripheral wins and chooses its drive type
      always_comb begin
        drv_out[gi] = 1'b0;
        drv_oe[gi] = 1'b0;
        drv_pull[gi] = 1'b0;
        if (alt.out_en[gi]) begin
          drv_out[gi] = alt.out_val[gi]; // see (R16) see (R17)
          drv_oe[gi] = !alt.open_drain[gi] || !alt.out_val[gi];
        end else if (is_out) begin
          drv_out[gi] = pin_data_latch_ff[gi] && port_pin_option_ff[gi]; // see (R15)
          drv_oe[gi] = port_pin_option_ff[gi] || !pin_data_latch_ff[gi]; // see (R23)
        end else begin
          drv_pull[gi] = port_pin_option_ff[gi] && PULL_UP_CAPABLE[gi]; // see (R4) see (R23)
        end
      end

      // interrupt enable: input with option set on a capable pin
      assign irq_en = IRQ_CAPABLE[gi] && !is_out && port_pin_option_ff[gi]; // see (R1)
      assign rise = pin_level[gi] && !pin_level_prev[gi];
      assign fall = !pin_level[gi] && pin_level_prev[gi];

      // qualify by the selected sensitivity
      always_comb begin
        case (gpei_sens_type'(sens_ff))
          GPEI_SENS_FALL_LOW: irq_qual[gi] = irq_en && (fall || !pin_level[gi]); // see (R24)
          GPEI_SENS_RISE: irq_qual[gi] = irq_en && rise;
          GPEI_SENS_FALL: irq_qual[gi] = irq_en && fall;
          GPEI_SENS_BOTH: irq_qual[gi] = irq_en && (rise || fall);
          default: irq_qual[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // external interrupt request latch
  // ------------------------------------------------------------
  logic irq_req_ff;
  logic nxt_irq_req;
  logic irq_set;

  // qualified pins are ORed into one event
  assign irq_set = |irq_qual; // see (R10) see (R8)

  // fetch or a sensitivity change clears; a new event wins over the clear
  always_comb begin
    nxt_irq_req = irq_req_ff;
    if (vector_fetch || sens_changed) begin
      nxt_irq_req = 1'b0; // see (R11) see (R12)
    end
    if (irq_set) begin
      nxt_irq_req = 1'b1;
    end
  end

  // latch register, hidden from the register map
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_req_ff <= 1'b0;
    end else begin
      irq_req_ff <= nxt_irq_req;
    end
  end

  assign ext_irq_req = irq_req_ff;

  // ------------------------------------------------------------
  // read port and pad drive registers
  // ------------------------------------------------------------
  logic [GPEI_PINS-1:0] rdata_ff;
  logic [GPEI_PINS-1:0] nxt_rdata;
  gpei_pad_type pad_ff;
  gpei_pad_type nxt_pad;

  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = GPEI_RST_READ_DATA;
    if (bus_req.rd) begin
      case (bus_req.addr)
        GPEI_OFS_PORT_PIN_DATA: nxt_rdata = read_view;
        GPEI_OFS_PORT_PIN_DIRECTION: nxt_rdata = port_pin_direction_ff;
        GPEI_OFS_PORT_PIN_OPTION: nxt_rdata = port_pin_option_ff;
        GPEI_OFS_EXT_IRQ_SENSITIVITY_REG: nxt_rdata = {6'h00, sens_ff};
        default: nxt_rdata = GPEI_RST_READ_DATA;
      endcase
    end
    nxt_pad.out = drv_out;
    nxt_pad.oe = drv_oe;
    nxt_pad.pull_up = drv_pull;
  end

  // register read data and pad controls
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_ff <= GPEI_RST_READ_DATA;
      pad_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
      pad_ff <= nxt_pad;
    end
  end

  assign bus_rdata = rdata_ff;
  assign pad = pad_ff;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  logic rd_data_out;
  assign rd_data_out = bus_req.rd && (bus_req.addr == GPEI_OFS_PORT_PIN_DATA)
    && (port_pin_direction_ff == 8'hff);

  logic [GPEI_PINS-1:0] od_high;
  logic [GPEI_PINS-1:0] pull_want;

  // pins that must float next cycle, and pins that must be pulled up next cycle
  assign od_high = port_pin_direction_ff & ~port_pin_option_ff
    & pin_data_latch_ff & ~alt.out_en;
  assign pull_want = ~port_pin_direction_ff & port_pin_option_ff
    & PULL_UP_CAPABLE & ~alt.out_en;

  a_read_latch_out: assert property ( // see (R14)
    rd_data_out |=> bus_rdata == $past(pin_data_latch_ff))
    else $error("output-mode data read did not return the latch");

  a_input_no_drive: assert property ( // see (R5)
    (port_pin_direction_ff == 8'h00 && alt.out_en == 8'h00) |=> pad.oe == 8'h00)
    else $error("input pin is driven");

  a_sens_write_guard: assert property ( // see (R25)
    (bus_req.wr && bus_req.addr == GPEI_OFS_EXT_IRQ_SENSITIVITY_REG
      && condition_code_reg != GPEI_CC_LEVEL_UNLOCK) |=> $stable(sens_ff))
    else $error("locked sensitivity bits changed");

  a_sens_change_clear: assert property ( // see (R12)
    (sens_changed && !irq_set) |=> !ext_irq_req)
    else $error("sensitivity change left request pending");

  a_fetch_clears_req: assert property ( // see (R11)
    (vector_fetch && !irq_set) |=> !ext_irq_req)
    else $error("vector fetch did not clear request");

  a_event_sets_req: assert property ( // see (R8)
    irq_set |=> ext_irq_req)
    else $error("qualified event did not raise request");

  a_rise_raises_req: assert property ( // see (R10)
    (sens_ff == GPEI_SENS_RISE && IRQ_CAPABLE[0] && port_pin_option_ff[0]
      && !port_pin_direction_ff[0] && $rose(pin_level[0])) |=> ext_irq_req)
    else $error("rising edge on pin 0 lost");

  a_push_pull_drive: assert property ( // see (R15)
    (port_pin_direction_ff[0] && port_pin_option_ff[0] && !alt.out_en[0])
      |=> pad.oe[0] && pad.out[0] == $past(pin_data_latch_ff[0]))
    else $error("push-pull pin 0 not driving latch");

  a_open_drain_release: assert property ( // see (R15)
    1'b1 |=> (pad.oe & $past(od_high)) == 8'h00)
    else $error("open-drain pin holding one not released");

  a_pull_up_input: assert property ( // see (R23)
    1'b1 |=> pad.pull_up == $past(pull_want))
    else $error("pull-up does not follow the input option");

  a_alt_override: assert property ( // see (R17)
    (alt.out_en[0] && !alt.open_drain[0]) |=> pad.oe[0] && pad.out[0] == $past(alt.out_val[0]))
    else $error("alternate output not forced on pin 0");

  a_alt_in_latch: assert property ( // see (R21)
    port_pin_direction_ff[0] |-> alt_in[0] == pin_data_latch_ff[0])
    else $error("peripheral input does not follow latch");

  a_data_read_pin: assert property ( // see (R3)
    (bus_req.rd && bus_req.addr == GPEI_OFS_PORT_PIN_DATA && port_pin_direction_ff == 8'h00
      && alt.out_en == 8'h00) |=> bus_rdata == $past(pin_level))
    else $error("input-mode data read did not return the pin level");

  a_low_level_holds: assert property ( // see (R24)
    (sens_ff == GPEI_SENS_FALL_LOW && IRQ_CAPABLE[1] && port_pin_option_ff[1]
      && !port_pin_direction_ff[1] && !pin_level[1]) |=> ext_irq_req)
    else $error("low level on pin 1 did not hold the request");

  c_req_raised: cover property (!ext_irq_req ##1 ext_irq_req);
  c_fetch_taken: cover property (ext_irq_req && vector_fetch ##1 !ext_irq_req);
  c_sens_written: cover property (sens_changed);
  c_od_released: cover property (pad.oe[0] ##1 !pad.oe[0] && port_pin_direction_ff[0]);
  c_set_beats_fetch: cover property (vector_fetch && irq_set ##1 ext_irq_req);

endmodule

// ### hw/gpei_pkg.sv
// package: widths, register map, reset values and carrier types of the gpio port
package gpei_pkg;

  // ------------------------------------------------------------
  // port geometry
  // ------------------------------------------------------------
  localparam int GPEI_PINS = 8;
  localparam int GPEI_ADDR_W = 3;
  localparam int GPEI_SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [GPEI_ADDR_W-1:0] GPEI_OFS_PORT_PIN_DATA = 3'h0;
  localparam logic [GPEI_ADDR_W-1:0] GPEI_OFS_PORT_PIN_DIRECTION = 3'h1;
  localparam logic [GPEI_ADDR_W-1:0] GPEI_OFS_PORT_PIN_OPTION = 3'h2;
  localparam logic [GPEI_ADDR_W-1:0] GPEI_OFS_EXT_IRQ_SENSITIVITY_REG = 3'h3;

  // ------------------------------------------------------------
  // field positions of the sensitivity register
  // ------------------------------------------------------------
  localparam int GPEI_SENS_FIELD_LOW_POS = 0;
  localparam int GPEI_SENS_FIELD_HIGH_POS = 1;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [GPEI_PINS-1:0] GPEI_RST_PIN_DATA = 8'h00;
  localparam logic [GPEI_PINS-1:0] GPEI_RST_PIN_DIRECTION = 8'h00;
  localparam logic [GPEI_PINS-1:0] GPEI_RST_PIN_OPTION = 8'h00;
  localparam logic [1:0] GPEI_RST_SENSITIVITY = 2'h0;
  localparam logic [GPEI_PINS-1:0] GPEI_RST_READ_DATA = 8'h00;

  // ------------------------------------------------------------
  // interrupt mask level that unlocks the sensitivity bits
  // ------------------------------------------------------------
  localparam logic [1:0] GPEI_CC_LEVEL_UNLOCK = 2'h3;

  // ------------------------------------------------------------
  // sensitivity encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    GPEI_SENS_FALL_LOW = 2'h0,
    GPEI_SENS_RISE = 2'h1,
    GPEI_SENS_FALL = 2'h2,
    GPEI_SENS_BOTH = 2'h3
  } gpei_sens_type;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [GPEI_ADDR_W-1:0] addr;
    logic [GPEI_PINS-1:0] wdata;
    logic wr;
    logic rd;
  } gpei_bus_req_type;

  typedef struct packed {
    logic [GPEI_PINS-1:0] out;
    logic [GPEI_PINS-1:0] oe;
    logic [GPEI_PINS-1:0] pull_up;
  } gpei_pad_type;

  typedef struct packed {
    logic [GPEI_PINS-1:0] out_en;
    logic [GPEI_PINS-1:0] out_val;
    logic [GPEI_PINS-1:0] open_drain;
  } gpei_alt_type;

endpackage

// ### hw/gpei_pin_sync.sv
// module: two-stage pin synchroniser with a delayed copy for edge detection
module gpei_pin_sync
  import gpei_pkg::*;
#(
  parameter int WIDTH = GPEI_PINS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] level_prev
);

  // ------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;
  logic [WIDTH-1:0] nxt_prev;

  // next values: stage1 is read only by stage2
  always_comb begin
    nxt_stage1 = pin_in;
    nxt_stage2 = stage1_ff;
    nxt_prev = stage2_ff;
  end

  // register the chain
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      prev_ff <= '0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
      prev_ff <= nxt_prev;
    end
  end

  assign level = stage2_ff;
  assign level_prev = prev_ff;

endmodule

// ### tb/gpei_board.sv
// board model: resolves each pad level from port drive, board drive, pull-up or a float pattern
module gpei_board
  import gpei_pkg::*;
(
  input wire logic clock,
  input wire gpei_pad_type pad,
  input wire logic [GPEI_PINS-1:0] board_en,
  input wire logic [GPEI_PINS-1:0] board_val,
  output logic [GPEI_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic float_ff = 1'b0;
  logic nxt_float;

  // ------------------------------------------------------------
  // floating pattern
  // ------------------------------------------------------------
  // an undriven pad flips every cycle so a stale value never looks valid
  always_comb begin
    nxt_float = ~float_ff;
  end

  always_ff @(posedge clock) begin
    float_ff <= nxt_float;
  end

  // ------------------------------------------------------------
  // pad resolution
  // ------------------------------------------------------------
  // port drive wins, then the board, then the pull-up, else the pad floats
  always_comb begin
    for (int i = 0; i < GPEI_PINS; i++) begin
      if (pad.oe[i]) begin
        pin_in[i] = pad.out[i];
      end else if (board_en[i]) begin
        pin_in[i] = board_val[i];
      end else if (pad.pull_up[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_ff ^ i[0];
      end
    end
  end
endmodule

// ### tb/gpei_port_tb.sv
// testbench: register, pin, alternate function and interrupt checks of the gpio port
module gpei_port_tb
  import gpei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic rst_b;
  gpei_bus_req_type bus_req;
  logic [7:0] bus_rdata;
  logic [1:0] condition_code_reg;
  logic vector_fetch;
  logic ext_irq_req;
  logic [7:0] pin_in;
  logic [7:0] alt_in;
  logic [7:0] board_en;
  logic [7:0] board_val;
  gpei_pad_type pad;
  gpei_alt_type alt;
  int miscompares;
  int compares;
  int cycles;

  // ------------------------------------------------------------
  // design and board
  // ------------------------------------------------------------
  gpei_port i_gpei_port (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .condition_code_reg(condition_code_reg), .vector_fetch(vector_fetch),
    .ext_irq_req(ext_irq_req), .pin_in(pin_in), .pad(pad), .alt(alt), .alt_in(alt_in));

  gpei_board i_gpei_board (.clock(clock), .pad(pad), .board_en(board_en),
    .board_val(board_val), .pin_in(pin_in));

  // ------------------------------------------------------------
  // clock and timeout
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // cuts a hang short well after the sequence should have ended
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; a gap cycle follows so strobes never merge
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pin_set(input logic [7:0] v);
    @(posedge clock);
    board_val <= v;
    settle(4);
  endtask

  task automatic fetch();
    @(posedge clock);
    vector_fetch <= 1'b1;
    @(posedge clock);
    vector_fetch <= 1'b0;
    settle(2);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    condition_code_reg = 2'h0;
    vector_fetch = 1'b0;
    board_en = 8'hff;
    board_val = 8'h00;
    alt = '0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    // reset values and an unmapped offset; the board holds every pin low
    reg_rd(GPEI_OFS_PORT_PIN_DATA, 8'h00);
    reg_rd(GPEI_OFS_PORT_PIN_DIRECTION, 8'h00);
    reg_rd(GPEI_OFS_PORT_PIN_OPTION, 8'h00);
    reg_rd(GPEI_OFS_EXT_IRQ_SENSITIVITY_REG, 8'h00);
    reg_rd(3'h5, 8'h00);
    chk(pad.oe | pad.pull_up, 8'h00);
    // input mode: latch write leaves the pads alone, reads give pin levels
    board_en <= 8'hff;
    board_val <= 8'h5a;
    reg_wr(GPEI_OFS_PORT_PIN_DATA, 8'hff);
    settle(4);
    chk(pad.oe, 8'h00);
    reg_rd(GPEI_OFS_PORT_PIN_DATA, 8'h5a);
    // pull-up variant on the upper nibble only
    board_en <= 8'h0f;
    reg_wr(GPEI_OFS_PORT_PIN_OPTION, 8'hf0);
    settle(4);
    chk(pad.pull_up, 8'hf0);
    reg_rd(GPEI_OFS_PORT_PIN_DATA, 8'hfa);
    reg_rd(GPEI_OFS_PORT_PIN_OPTION, 8'hf0);
    // outputs: push-pull low nibble, open drain high nibble
    board_en <= 8'h00;
    reg_wr(GPEI_OFS_PORT_PIN_DATA, 8'ha5);
    reg_wr(GPEI_OFS_PORT_PIN_OPTION, 8'h0f);
    reg_wr(GPEI_OFS_PORT_PIN_DIRECTION, 8'hff);
    settle(4);
    chk(pad.oe, 8'h5f);
    chk(pad.out & pad.oe, 8'h05);
    chk(pad.pull_up, 8'h00);
    reg_rd(GPEI_OFS_PORT_PIN_DATA, 8'ha5);
    chk(alt_in, 8'ha5);
    reg_wr(GPEI_OFS_PORT_PIN_DATA, 8'h0f);
    settle(2);
    chk(pad.oe, 8'hff);
    chk(pad.out & pad.oe, 8'h0f);
    // peripheral drives pins 1:0 while the port is a floating input
    reg_wr(GPEI_OFS_PORT_PIN_DIRECTION, 8'h00);
    reg_wr(GPEI_OFS_PORT_PIN_OPTION, 8'h00);
    board_en <= 8'hff;
    board_val <= 8'h3c;
    alt.out_en <= 8'h03;
    alt.out_val <= 8'h03;
    alt.open_drain <= 8'h02;
    settle(4);
    chk(pad.oe & 8'h03, 8'h01);
    chk(pad.out & 8'h01, 8'h01);
    reg_rd(GPEI_OFS_PORT_PIN_DATA, 8'h3f);
    chk(alt_in, 8'h3d);
    alt <= '0;
    // interrupts on pins 1:0, every sensitivity code, events on pin 1
    condition_code_reg <= GPEI_CC_LEVEL_UNLOCK;
    board_val <= 8'hff;
    reg_wr(GPEI_OFS_PORT_PIN_OPTION, 8'h03);
    settle(4);
    // floating pins during the mode changes above left a request; the fetch drops it
    fetch();
    chk(8'(ext_irq_req), 8'h00);
    for (int m = 0; m < 4; m++) begin
      reg_wr(GPEI_OFS_EXT_IRQ_SENSITIVITY_REG, 8'(m));
      settle(2);
      chk(8'(ext_irq_req), 8'h00);
      reg_rd(GPEI_OFS_EXT_IRQ_SENSITIVITY_REG, 8'(m));
      pin_set(8'hfd);
      chk(8'(ext_irq_req), 8'(m != 1));
      fetch();
      chk(8'(ext_irq_req), 8'(m == 0));
      pin_set(8'hff);
      chk(8'(ext_irq_req), 8'(m != 2));
      fetch();
      chk(8'(ext_irq_req), 8'h00);
    end
    // locked sensitivity write neither lands nor clears a pending request
    pin_set(8'hfc);
    condition_code_reg <= 2'h2;
    reg_wr(GPEI_OFS_EXT_IRQ_SENSITIVITY_REG, 8'h01);
    settle(2);
    chk(8'(ext_irq_req), 8'h01);
    reg_rd(GPEI_OFS_EXT_IRQ_SENSITIVITY_REG, 8'h03);
    condition_code_reg <= GPEI_CC_LEVEL_UNLOCK;
    reg_wr(GPEI_OFS_EXT_IRQ_SENSITIVITY_REG, 8'h01);
    settle(2);
    chk(8'(ext_irq_req), 8'h00);
    // both enabled pins rise together under rising-edge sensitivity
    pin_set(8'hff);
    chk(8'(ext_irq_req), 8'h01);
    fetch();
    // pin 2 has no interrupt option, so its edges stay silent
    pin_set(8'hfb);
    pin_set(8'hff);
    chk(8'(ext_irq_req), 8'h00);
    finish_test();
  end
endmodule
